/* scp_pkg.sv */
`default_nettype none
// ==========================================================
// shared types and constants of the system control pipeline
package scp_pkg;

	// width of a general register index
	localparam int REG_IDX_W = 4;
	// width of the execute slot counter
	localparam int EX_CNT_W = 3;

	// execute slots taken by each instruction shape
	localparam logic [EX_CNT_W-1:0] EX_SLOTS_SINGLE = 3'h1;
	localparam logic [EX_CNT_W-1:0] EX_SLOTS_BANKED = 3'h2;
	localparam logic [EX_CNT_W-1:0] EX_SLOTS_RETURN = 3'h3;
	localparam logic [EX_CNT_W-1:0] EX_SLOTS_TRAP = 3'h4;
	localparam logic [EX_CNT_W-1:0] EX_SLOTS_TRAP_DSP = 3'h6;
	// counter value while the last execute slot runs
	localparam logic [EX_CNT_W-1:0] EX_SLOT_LAST = 3'h1;
	localparam logic [EX_CNT_W-1:0] EX_CNT_IDLE = 3'h0;
	localparam logic [REG_IDX_W-1:0] REG_IDX_NONE = 4'h0;

	// ==========================================================
	// instruction groups as seen by the sequencer
	typedef enum logic [3:0] {
		cls_other,
		cls_store_control_reg_predecrement,
		cls_store_banked_predecrement,
		cls_clear_accumulator,
		cls_move_to_accumulator,
		cls_load_accumulator_postincrement,
		cls_move_from_accumulator,
		cls_store_accumulator_predecrement,
		cls_status_update,
		cls_exception_return,
		cls_software_trap,
		cls_sleep
	} scp_class_t;

endpackage : scp_pkg
`default_nettype wire

/* scp_reset_sync.sv */
`default_nettype none
// ==========================================================
// reset release synchroniser
module scp_reset_sync (
	input wire logic clock,
	input wire logic rst_n,
	output logic rst_sync_n
);
	import scp_pkg::*;

	logic stage1_q;

	// assert at once, release two edges later so no flop sees a ragged edge
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stage1_q <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			stage1_q <= 1'b1;
			rst_sync_n <= stage1_q;
		end
	end

endmodule : scp_reset_sync
`default_nettype wire

/* scp_pipe_ctrl.sv */
// Overview of operation
// - control register store: five stages, pointer written back
// - its memory slot holds off instruction fetch
// - dsp variant: next decode waits one slot
// - banked register store: six stages, two execute
// - banked store stalls next decode one cycle
// - banked store memory slot holds off fetch
// - accumulator clear/move-in: four stages, multiplier, contends
// - accumulator load: four stages, memory and multiplier
// - multiplier user after accumulator transfer stalls
// - accumulator move-out: five stages, dependent reader stalls
// - exception return: three execute, delayed branch
// - instruction after delay slot fetched, then dropped
// - return target fetched right after last execute
// - software trap: four execute, no delay slot
// - two instructions after trap are dropped
// - handler fetched right after last trap execute
// - dsp variant trap uses six execute slots
// - sleep: three stages, holds next fetch
// - after sleep executes, enter sleep or standby
// - status reader waits for pending status update
`default_nettype none
module scp_pipe_ctrl (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic dsp_variant,
	input wire logic standby_select,
	input wire logic wake_req,
	input wire logic fetch_valid,
	input wire scp_pkg::scp_class_t fetch_class,
	input wire logic [scp_pkg::REG_IDX_W-1:0] fetch_dest,
	input wire logic [scp_pkg::REG_IDX_W-1:0] fetch_src_a,
	input wire logic [scp_pkg::REG_IDX_W-1:0] fetch_src_b,
	input wire logic fetch_reads_status,
	input wire logic fetch_uses_mult,
	output logic fetch_req_q,
	output logic fetch_redirect_q,
	output logic ex_valid_q,
	output var scp_pkg::scp_class_t ex_class_q,
	output logic mem_access_q,
	output logic mult_access_q,
	output logic pointer_writeback_q,
	output logic result_writeback_q,
	output logic status_writeback_q,
	output logic [scp_pkg::REG_IDX_W-1:0] writeback_dest_q,
	output logic squash_q,
	output logic sleep_mode_q,
	output logic standby_mode_q
);
	import scp_pkg::*;

	// ==========================================================
	// instruction shape lookups

	// execute slots for one instruction
	function automatic logic [EX_CNT_W-1:0] ex_slots(input scp_class_t c, input logic dsp);
		logic [EX_CNT_W-1:0] n;
		n = EX_SLOTS_SINGLE;
		unique case (c)
			cls_store_banked_predecrement: n = EX_SLOTS_BANKED;
			cls_exception_return: n = EX_SLOTS_RETURN;
			cls_software_trap: n = dsp ? EX_SLOTS_TRAP_DSP : EX_SLOTS_TRAP;
			default: n = EX_SLOTS_SINGLE;
		endcase
		return n;
	endfunction : ex_slots

	// instruction owns a memory stage
	function automatic logic has_ma(input scp_class_t c);
		return c inside {cls_store_control_reg_predecrement, cls_store_banked_predecrement,
			cls_clear_accumulator, cls_move_to_accumulator, cls_load_accumulator_postincrement,
			cls_move_from_accumulator, cls_store_accumulator_predecrement, cls_status_update};
	endfunction : has_ma

	// memory stage takes the bus away from instruction fetch
	function automatic logic ma_bus(input scp_class_t c);
		return has_ma(c) && (c != cls_status_update);
	endfunction : ma_bus

	// memory stage reaches data memory
	function automatic logic ma_mem(input scp_class_t c);
		return c inside {cls_store_control_reg_predecrement, cls_store_banked_predecrement,
			cls_load_accumulator_postincrement, cls_store_accumulator_predecrement};
	endfunction : ma_mem

	// accumulator and dsp register transfers reach the multiplier
	function automatic logic acc_xfer(input scp_class_t c);
		return c inside {cls_clear_accumulator, cls_move_to_accumulator,
			cls_load_accumulator_postincrement, cls_move_from_accumulator,
			cls_store_accumulator_predecrement};
	endfunction : acc_xfer

	// writeback of a decremented address register
	function automatic logic ptr_wb(input scp_class_t c);
		return c inside {cls_store_control_reg_predecrement, cls_store_banked_predecrement,
			cls_store_accumulator_predecrement};
	endfunction : ptr_wb

	// instruction changes the program flow after its execute slots
	function automatic logic branches(input scp_class_t c);
		return (c == cls_exception_return) || (c == cls_software_trap);
	endfunction : branches

	// ==========================================================
	// reset and variant strap

	logic rst_sync_n;
	logic dsp_taken_q;
	logic dsp_q;

	scp_reset_sync u_reset_sync (
		.clock(clock),
		.rst_n(rst_n),
		.rst_sync_n(rst_sync_n)
	);

	// strap caught once after release, never under the reset itself
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			dsp_taken_q <= 1'b0;
			dsp_q <= 1'b0;
		end else if (!dsp_taken_q) begin
			dsp_taken_q <= 1'b1;
			dsp_q <= dsp_variant;
		end
	end

	// ==========================================================
	// stage registers

	logic fb_v_q;
	scp_class_t fb_cls_q;
	logic [REG_IDX_W-1:0] fb_dest_q;
	logic [REG_IDX_W-1:0] fb_src_a_q;
	logic [REG_IDX_W-1:0] fb_src_b_q;
	logic fb_rs_q;
	logic fb_um_q;
	logic id_v_q;
	scp_class_t id_cls_q;
	logic [REG_IDX_W-1:0] id_dest_q;
	logic [REG_IDX_W-1:0] id_src_a_q;
	logic [REG_IDX_W-1:0] id_src_b_q;
	logic id_rs_q;
	logic id_um_q;
	logic [EX_CNT_W-1:0] ex_cnt_q;
	logic [REG_IDX_W-1:0] ex_dest_q;
	logic ma_v_q;
	scp_class_t ma_cls_q;
	logic [REG_IDX_W-1:0] ma_dest_q;
	logic dsp_hold_q;

	// ==========================================================
	// stall and drop decisions

	logic incoming;
	logic ex_busy;
	logic ex_leaves;
	logic status_hazard;
	logic mult_hazard;
	logic dest_hazard;
	logic sleep_hold;
	logic id_stall;
	logic id_adv;
	logic id_free;
	logic kill_id;
	logic kill_fb;
	logic fb_next;
	logic ma_bus_next;
	logic redirect_due;

	// a fetched word only exists in the slot it was requested
	assign incoming = fetch_valid && fetch_req_q;

	// a multi-slot execute holds decode while later stages drain
	assign ex_busy = ex_valid_q && (ex_cnt_q > EX_SLOT_LAST);
	assign ex_leaves = ex_valid_q && !ex_busy;

	// reader waits while the update sits in execute or memory
	assign status_hazard = id_rs_q &&
		((ex_valid_q && ex_class_q == cls_status_update) || (ma_v_q && ma_cls_q == cls_status_update));

	// multiplier user directly behind an accumulator transfer
	assign mult_hazard = id_um_q && ex_valid_q && acc_xfer(ex_class_q);

	// reader of the register an accumulator move-out is writing
	assign dest_hazard = ex_valid_q &&
		(ex_class_q inside {cls_move_from_accumulator, cls_store_accumulator_predecrement}) &&
		(id_src_a_q == ex_dest_q || id_src_b_q == ex_dest_q);

	// nothing behind a sleep proceeds until wake
	assign sleep_hold = sleep_mode_q || standby_mode_q || (ex_valid_q && ex_class_q == cls_sleep);

	assign id_stall = ex_busy || status_hazard || mult_hazard || dest_hazard || dsp_hold_q || sleep_hold;

	// a trap in execute drops whatever sits in decode
	assign kill_id = ex_valid_q && ex_class_q == cls_software_trap;

	// a trap or return in execute drops everything fetched behind decode
	assign kill_fb = ex_valid_q && branches(ex_class_q);

	assign id_adv = id_v_q && !id_stall && !kill_id;
	assign id_free = !id_v_q || id_adv || kill_id;

	// fetch buffer still occupied in the next slot
	assign fb_next = !kill_fb && !id_free && (fb_v_q || incoming);

	// next slot has a memory stage that owns the bus
	assign ma_bus_next = ex_leaves && ma_bus(ex_class_q);

	// last execute slot of a trap or return
	assign redirect_due = ex_leaves && branches(ex_class_q);

	// ==========================================================
	// fetch buffer: holds a word fetched while decode stalls

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			fb_v_q <= 1'b0;
			fb_cls_q <= cls_other;
			fb_dest_q <= REG_IDX_NONE;
			fb_src_a_q <= REG_IDX_NONE;
			fb_src_b_q <= REG_IDX_NONE;
			fb_rs_q <= 1'b0;
			fb_um_q <= 1'b0;
		end else begin
			fb_v_q <= fb_next;
			if (!fb_v_q && incoming) begin
				fb_cls_q <= fetch_class;
				fb_dest_q <= fetch_dest;
				fb_src_a_q <= fetch_src_a;
				fb_src_b_q <= fetch_src_b;
				fb_rs_q <= fetch_reads_status;
				fb_um_q <= fetch_uses_mult;
			end
		end
	end

	// ==========================================================
	// decode stage

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			id_v_q <= 1'b0;
			id_cls_q <= cls_other;
			id_dest_q <= REG_IDX_NONE;
			id_src_a_q <= REG_IDX_NONE;
			id_src_b_q <= REG_IDX_NONE;
			id_rs_q <= 1'b0;
			id_um_q <= 1'b0;
		end else if (id_free) begin
			// buffered word goes first so program order holds
			if (fb_v_q) begin
				id_v_q <= !kill_fb;
				id_cls_q <= fb_cls_q;
				id_dest_q <= fb_dest_q;
				id_src_a_q <= fb_src_a_q;
				id_src_b_q <= fb_src_b_q;
				id_rs_q <= fb_rs_q;
				id_um_q <= fb_um_q;
			end else begin
				id_v_q <= incoming && !kill_fb;
				id_cls_q <= fetch_class;
				id_dest_q <= fetch_dest;
				id_src_a_q <= fetch_src_a;
				id_src_b_q <= fetch_src_b;
				id_rs_q <= fetch_reads_status;
				id_um_q <= fetch_uses_mult;
			end
		end
	end

	// ==========================================================
	// execute stage with its slot counter

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ex_valid_q <= 1'b0;
			ex_class_q <= cls_other;
			ex_cnt_q <= EX_CNT_IDLE;
			ex_dest_q <= REG_IDX_NONE;
		end else if (ex_busy) begin
			ex_cnt_q <= ex_cnt_q - EX_SLOT_LAST;
		end else if (id_adv) begin
			ex_valid_q <= 1'b1;
			ex_class_q <= id_cls_q;
			ex_cnt_q <= ex_slots(id_cls_q, dsp_q);
			ex_dest_q <= id_dest_q;
		end else begin
			ex_valid_q <= 1'b0;
			ex_cnt_q <= EX_CNT_IDLE;
		end
	end

	// dsp variant: control store delays the next decode one slot
	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			dsp_hold_q <= 1'b0;
		end else begin
			dsp_hold_q <= dsp_q && id_adv && id_cls_q == cls_store_control_reg_predecrement;
		end
	end

	// ==========================================================
	// memory stage: bus and multiplier strobes

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ma_v_q <= 1'b0;
			ma_cls_q <= cls_other;
			ma_dest_q <= REG_IDX_NONE;
			mem_access_q <= 1'b0;
			mult_access_q <= 1'b0;
		end else begin
			ma_v_q <= ex_leaves && has_ma(ex_class_q);
			ma_cls_q <= ex_class_q;
			ma_dest_q <= ex_dest_q;
			mem_access_q <= ex_leaves && ma_mem(ex_class_q);
			mult_access_q <= ex_leaves && acc_xfer(ex_class_q);
		end
	end

	// ==========================================================
	// writeback stage strobes

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pointer_writeback_q <= 1'b0;
			result_writeback_q <= 1'b0;
			status_writeback_q <= 1'b0;
			writeback_dest_q <= REG_IDX_NONE;
		end else begin
			pointer_writeback_q <= ma_v_q && ptr_wb(ma_cls_q);
			result_writeback_q <= ma_v_q && ma_cls_q == cls_move_from_accumulator;
			status_writeback_q <= ma_v_q && ma_cls_q == cls_status_update;
			writeback_dest_q <= ma_dest_q;
		end
	end

	// ==========================================================
	// instruction fetch request
	// the request is decided one slot ahead from the present stage contents,
	// so the fetch port stays a plain flop at the cost of a one-word buffer

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			fetch_req_q <= 1'b0;
			fetch_redirect_q <= 1'b0;
		end else if (redirect_due) begin
			fetch_req_q <= 1'b1;
			fetch_redirect_q <= 1'b1;
		end else begin
			// a trap or return past its first execute slot fetches nothing more
			fetch_req_q <= !fb_next && !ma_bus_next && !kill_fb && !sleep_hold;
			fetch_redirect_q <= 1'b0;
		end
	end

	// ==========================================================
	// squash strobe: one pulse per slot in which a word is dropped

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			squash_q <= 1'b0;
		end else begin
			squash_q <= (kill_id && id_v_q) || (kill_fb && (fb_v_q || incoming));
		end
	end

	// ==========================================================
	// low power entry and wake

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			sleep_mode_q <= 1'b0;
			standby_mode_q <= 1'b0;
		end else if (wake_req) begin
			// wake wins so a late wake is never lost behind the entry
			sleep_mode_q <= 1'b0;
			standby_mode_q <= 1'b0;
		end else if (ex_valid_q && ex_class_q == cls_sleep) begin
			sleep_mode_q <= !standby_select;
			standby_mode_q <= standby_select;
		end
	end

endmodule : scp_pipe_ctrl
`default_nettype wire

/* scp_pipe_ctrl_monitor.sv */
`default_nettype none
// ==========================================================
// port-level checker of the pipeline sequencer
module scp_pipe_ctrl_monitor
	import scp_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic dsp_variant,
	input wire logic standby_select,
	input wire logic wake_req,
	input wire logic fetch_req_q,
	input wire logic fetch_redirect_q,
	input wire logic ex_valid_q,
	input wire scp_class_t ex_class_q,
	input wire logic mem_access_q,
	input wire logic mult_access_q,
	input wire logic pointer_writeback_q,
	input wire logic result_writeback_q,
	input wire logic squash_q,
	input wire logic sleep_mode_q,
	input wire logic standby_mode_q
);
	timeunit 1ns;
	timeprecision 100ps;
	// ==========================================================
	// class in execute; empty slots never match
	wire logic cs = ex_valid_q && ex_class_q == cls_store_control_reg_predecrement;
	wire logic bk = ex_valid_q && ex_class_q == cls_store_banked_predecrement;
	wire logic tr = ex_valid_q && ex_class_q == cls_software_trap;
	wire logic rt = ex_valid_q && ex_class_q == cls_exception_return;
	wire logic slp = ex_valid_q && ex_class_q == cls_sleep;
	wire logic mo = ex_valid_q && ex_class_q == cls_move_from_accumulator;
	wire logic ldst = ex_valid_q && ex_class_q inside {cls_load_accumulator_postincrement,
		cls_store_accumulator_predecrement};
	wire logic ac = ex_valid_q && ex_class_q inside {cls_clear_accumulator, cls_move_to_accumulator,
		cls_load_accumulator_postincrement, cls_move_from_accumulator, cls_store_accumulator_predecrement};
	wire logic parked = sleep_mode_q || standby_mode_q;

	default clocking dc @(posedge clock); endclocking
	default disable iff (!rst_n);

	// ==========================================================
	// a memory slot owns the bus, so no fetch beside it
	bus_share_a: assert property ((mem_access_q || mult_access_q) |-> !fetch_req_q)
		else $error("fetch beside a memory slot");
	ctrl_store_a: assert property (cs |=> mem_access_q ##1 pointer_writeback_q)
		else $error("control store stages wrong");
	banked_store_a: assert property ($rose(bk) |-> bk[*2] ##1 mem_access_q ##1 pointer_writeback_q)
		else $error("banked store stages wrong");
	acc_mult_a: assert property (ac |=> mult_access_q)
		else $error("accumulator transfer missed multiplier");
	acc_mem_a: assert property (ldst |=> mem_access_q)
		else $error("accumulator memory slot missing");
	move_out_a: assert property (mo |-> ##2 result_writeback_q)
		else $error("move-out writeback missing");
	trap_len_a: assert property ($rose(tr) && !dsp_variant |-> tr[*4] ##1 (fetch_req_q && fetch_redirect_q))
		else $error("trap length or handler fetch wrong");
	trap_dsp_a: assert property ($rose(tr) && dsp_variant |-> tr[*6] ##1 (fetch_req_q && fetch_redirect_q))
		else $error("extended trap length wrong");
	ret_len_a: assert property ($rose(rt) |-> rt[*3] ##1 (fetch_redirect_q && ex_valid_q))
		else $error("return length or target fetch wrong");
	no_overrun_a: assert property ((tr || rt) && $past(tr || rt) |-> !fetch_req_q)
		else $error("fetch during later branch slots");
	sleep_entry_a: assert property (slp && !wake_req |=> standby_mode_q == $past(standby_select) && sleep_mode_q != $past(standby_select))
		else $error("low power mode not entered");
	sleep_hold_a: assert property (parked |-> !fetch_req_q)
		else $error("fetch while parked");
	wake_clear_a: assert property (parked && wake_req |=> !parked)
		else $error("wake did not clear mode");

	// main scenarios reached
	trap_c: cover property (tr ##1 !tr && fetch_redirect_q);
	ret_c: cover property (rt ##1 !rt && fetch_redirect_q);
	sleep_c: cover property (slp ##1 parked);
	squash_c: cover property (squash_q);
endmodule : scp_pipe_ctrl_monitor

bind scp_pipe_ctrl scp_pipe_ctrl_monitor u_mon (.clock(clock), .rst_n(rst_n), .dsp_variant(dsp_variant),
	.standby_select(standby_select), .wake_req(wake_req), .fetch_req_q(fetch_req_q),
	.fetch_redirect_q(fetch_redirect_q), .ex_valid_q(ex_valid_q), .ex_class_q(ex_class_q),
	.mem_access_q(mem_access_q), .mult_access_q(mult_access_q), .pointer_writeback_q(pointer_writeback_q),
	.result_writeback_q(result_writeback_q), .squash_q(squash_q), .sleep_mode_q(sleep_mode_q),
	.standby_mode_q(standby_mode_q));
`default_nettype wire

/* scp_fetch_model.sv */
`default_nettype none
// ==========================================================
// instruction memory answering the fetch bus
module scp_fetch_model
	import scp_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic fetch_req_q,
	output logic fetch_valid,
	output var scp_class_t fetch_class,
	output logic [REG_IDX_W-1:0] fetch_dest,
	output logic [REG_IDX_W-1:0] fetch_src_a,
	output logic [REG_IDX_W-1:0] fetch_src_b,
	output logic fetch_reads_status,
	output logic fetch_uses_mult
);
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		scp_class_t cls;
		logic [3:0] dst;
		logic [3:0] a;
		logic [3:0] b;
		logic rs;
		logic mu;
	} scp_word_t;
	scp_word_t prog [32];
	scp_word_t w;
	logic slow = 1'b0;
	logic tog;
	int ptr;

	// slow mode answers requests only in every other cycle
	assign fetch_valid = fetch_req_q && (!slow || tog);
	assign w = prog[ptr[4:0]];
	// outside an answer the word is junk, a sleep so a stray capture shows
	always_comb begin
		fetch_class = fetch_valid ? w.cls : cls_sleep;
		fetch_dest = fetch_valid ? w.dst : ~w.dst;
		fetch_src_a = fetch_valid ? w.a : ~w.a;
		fetch_src_b = fetch_valid ? w.b : ~w.b;
		fetch_reads_status = fetch_valid ? w.rs : ~w.rs;
		fetch_uses_mult = fetch_valid ? w.mu : ~w.mu;
	end
	// sequential words; a redirect simply takes the next one
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ptr <= 0;
			tog <= 1'b0;
		end else begin
			tog <= !tog;
			if (fetch_req_q && fetch_valid) ptr <= ptr + 1;
		end
	end
endmodule : scp_fetch_model
`default_nettype wire

/* scp_pipe_ctrl_tb.sv */
`default_nettype none
module scp_pipe_ctrl_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import scp_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic dsp_variant = 1'b0;
	logic standby_select = 1'b0;
	logic wake_req = 1'b0;
	logic fetch_valid, fetch_reads_status, fetch_uses_mult, fetch_req_q, fetch_redirect_q, ex_valid_q;
	logic mem_access_q, mult_access_q, pointer_writeback_q, result_writeback_q, status_writeback_q;
	logic squash_q, sleep_mode_q, standby_mode_q;
	scp_class_t fetch_class, ex_class_q;
	logic [REG_IDX_W-1:0] fetch_dest, fetch_src_a, fetch_src_b, writeback_dest_q;
	int bad_count = 0;
	int tests_run = 0;
	int cyc = 0;
	scp_class_t exs [64];
	logic [REG_IDX_W-1:0] wd [64];
	logic [63:0] fq, rd, ma, mu, pw, rw, sq, sm, sb, sw;

	scp_pipe_ctrl DUT (.clock(clock), .rst_n(rst_n), .dsp_variant(dsp_variant), .standby_select(standby_select),
		.wake_req(wake_req), .fetch_valid(fetch_valid), .fetch_class(fetch_class), .fetch_dest(fetch_dest),
		.fetch_src_a(fetch_src_a), .fetch_src_b(fetch_src_b), .fetch_reads_status(fetch_reads_status),
		.fetch_uses_mult(fetch_uses_mult), .fetch_req_q(fetch_req_q), .fetch_redirect_q(fetch_redirect_q),
		.ex_valid_q(ex_valid_q), .ex_class_q(ex_class_q), .mem_access_q(mem_access_q),
		.mult_access_q(mult_access_q), .pointer_writeback_q(pointer_writeback_q),
		.result_writeback_q(result_writeback_q), .status_writeback_q(status_writeback_q),
		.writeback_dest_q(writeback_dest_q), .squash_q(squash_q), .sleep_mode_q(sleep_mode_q),
		.standby_mode_q(standby_mode_q));
	scp_fetch_model mem (.clock(clock), .rst_n(rst_n), .fetch_req_q(fetch_req_q), .fetch_valid(fetch_valid),
		.fetch_class(fetch_class), .fetch_dest(fetch_dest), .fetch_src_a(fetch_src_a),
		.fetch_src_b(fetch_src_b), .fetch_reads_status(fetch_reads_status), .fetch_uses_mult(fetch_uses_mult));

	initial forever #2.5 clock = ~clock;
	// hang guard: whole run needs well under a thousand cycles
	always @(posedge clock) begin
		cyc++;
		if (cyc > 5000) begin
			bad_count++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask : chk
	// ==========================================================
	// trace of the ports, one entry per slot, sampled mid-cycle
	task automatic rec(input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clock);
			exs[i] = ex_valid_q === 1'b1 ? ex_class_q : cls_other;
			wd[i] = writeback_dest_q;
			fq[i] = fetch_req_q;
			rd[i] = fetch_redirect_q;
			ma[i] = mem_access_q;
			mu[i] = mult_access_q;
			pw[i] = pointer_writeback_q;
			rw[i] = result_writeback_q;
			sq[i] = squash_q;
			sm[i] = sleep_mode_q;
			sb[i] = standby_mode_q;
			sw[i] = status_writeback_q;
		end
	endtask : rec
	function automatic int first(input scp_class_t c);
		for (int i = 0; i < 64; i++) if (exs[i] === c) return i;
		return -1;
	endfunction : first
	// reset, load four words, release, trace; word 1 reads word 0's dest
	task automatic boot(input logic dsp, input scp_class_t c0, c1, c2, c3);
		@(posedge clock);
		rst_n <= 1'b0;
		dsp_variant <= dsp;
		for (int k = 0; k < 32; k++) mem.prog[k] = '{cls_other, 4'h0, 4'h0, 4'h0, 1'b0, 1'b0};
		mem.prog[0] = '{c0, 4'h5, 4'h0, 4'h0, 1'b0, 1'b0};
		mem.prog[1] = '{c1, 4'h0, 4'h5, 4'h5, 1'b1, 1'b1};
		mem.prog[2].cls = c2;
		mem.prog[3].cls = c3;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		rec(40);
	endtask : boot

	// ==========================================================
	// scenarios
	task automatic t_reset();
		// follower reads the status word, so it waits out execute and memory of the update
		boot(1'b0, cls_status_update, cls_sleep, cls_other, cls_other);
		chk(fq[2:0] === 3'h0 && fq[3] === 1'b1, "first fetch edge");
		chk(first(cls_status_update) == 5, "first execute slot");
		chk(sw[7] === 1'b1 && ma[6] === 1'b0 && first(cls_sleep) == 8, "status reader stall");
		$display("reset done");
	endtask : t_reset
	task automatic t_ctrl(input logic dsp);
		int t;
		boot(dsp, cls_store_control_reg_predecrement, cls_status_update, cls_other, cls_other);
		t = first(cls_store_control_reg_predecrement);
		chk(t >= 0 && ma[t+1] && !fq[t+1], "control store memory slot");
		chk(pw[t+2] && wd[t+2] === 4'h5, "pointer writeback");
		chk(first(cls_status_update) == t + (dsp ? 2 : 1), "follower decode");
		$display("control store done");
	endtask : t_ctrl
	task automatic t_banked();
		int t;
		boot(1'b0, cls_store_banked_predecrement, cls_status_update, cls_other, cls_other);
		t = first(cls_store_banked_predecrement);
		chk(t >= 0 && exs[t+1] === cls_store_banked_predecrement && pw[t+3], "banked stages");
		chk(ma[t+2] && !fq[t+2], "banked memory slot");
		chk(first(cls_status_update) == t + 2, "banked follower stall");
		$display("banked store done");
	endtask : t_banked
	task automatic t_acc();
		scp_class_t acl [5] = '{cls_clear_accumulator, cls_move_to_accumulator, cls_load_accumulator_postincrement,
			cls_move_from_accumulator, cls_store_accumulator_predecrement};
		int t;
		foreach (acl[k]) begin
			boot(1'b0, acl[k], cls_status_update, cls_other, cls_other);
			t = first(acl[k]);
			chk(t >= 0 && mu[t+1] && !fq[t+1], "multiplier slot");
			chk(ma[t+1] === (k == 2 || k == 4), "data memory slot");
			chk(first(cls_status_update) == t + 2, "multiplier user stall");
			if (k == 3) chk(rw[t+2] === 1'b1 && wd[t+2] === 4'h5, "move-out writeback");
		end
		$display("accumulator done");
	endtask : t_acc
	task automatic t_trap(input logic dsp);
		int t;
		int n;
		logic ok;
		n = dsp ? 6 : 4;
		boot(dsp, cls_software_trap, cls_sleep, cls_sleep, cls_move_from_accumulator);
		t = first(cls_software_trap);
		ok = t >= 0;
		for (int k = 1; k < n; k++) ok = ok && exs[t+k] === cls_software_trap && (k == 1 || !fq[t+k]);
		chk(ok, "trap execute slots");
		chk(fq[t+n] && rd[t+n] && first(cls_move_from_accumulator) == t + n + 2, "handler fetch");
		chk(first(cls_sleep) == -1 && sm === 64'h0 && sq !== 64'h0, "dropped words");
		$display("trap done");
	endtask : t_trap
	task automatic t_return();
		int t;
		boot(1'b0, cls_exception_return, cls_clear_accumulator, cls_sleep, cls_move_from_accumulator);
		t = first(cls_exception_return);
		chk(t >= 0 && exs[t+2] === cls_exception_return && mu[t+4], "return and delay slot");
		chk(exs[t+3] === cls_clear_accumulator && fq[t+3] && rd[t+3], "target fetch slot");
		chk(first(cls_sleep) == -1 && sm === 64'h0 && first(cls_move_from_accumulator) == t + 5, "dropped");
		$display("return done");
	endtask : t_return
	task automatic t_sleep(input logic s);
		int t;
		logic ok;
		@(posedge clock);
		standby_select <= s;
		mem.slow = 1'b1;
		boot(1'b0, cls_sleep, cls_status_update, cls_other, cls_other);
		t = first(cls_sleep);
		chk(t >= 0 && sm[t+1] === !s && sb[t+1] === s, "mode entry");
		ok = first(cls_status_update) == -1;
		for (int k = t + 1; k < 40; k++) ok = ok && !fq[k];
		chk(ok, "flow stopped");
		@(posedge clock);
		wake_req <= 1'b1;
		@(posedge clock);
		wake_req <= 1'b0;
		rec(30);
		chk(sm[0] === 1'b0 && sb[0] === 1'b0 && first(cls_status_update) >= 0, "wake resumes");
		mem.slow = 1'b0;
		$display("sleep done");
	endtask : t_sleep

	initial begin
		t_reset();
		t_ctrl(1'b0);
		t_ctrl(1'b1);
		t_banked();
		t_acc();
		t_trap(1'b0);
		t_trap(1'b1);
		t_return();
		t_sleep(1'b0);
		t_sleep(1'b1);
		stop_test();
	end
endmodule : scp_pipe_ctrl_tb
`default_nettype wire
